// ---- src/dcs_channel_flags.sv ----
`default_nettype none

module dcs_channel_flags (
   input  wire logic                ref_clk,   // System clock
   input  wire logic                rst_n,     // Async reset, active low
   input  wire logic                clkEn,     // Freezes state while low
   input  wire dcs_pkg::dcs_evt_t   events,    // Event pulses of this channel
   input  wire dcs_pkg::dcs_flags_t clearMask, // Ones clear matching flags
   output var  dcs_pkg::dcs_flags_t flags      // Sticky flags, registered
);

   dcs_pkg::dcs_flags_t setMask;
   dcs_pkg::dcs_flags_t next_flags;

   ////////////////////////////////////////////////////////////////////////////
   // Set terms from the engine events
   always_comb begin
      setMask.anyFlag   = events.faultEvt | events.halfEvt
                        | events.doneEvt;                      // RULE_01
      setMask.doneFlag  = events.doneEvt;                      // RULE_02
      setMask.halfFlag  = events.halfEvt;                      // RULE_03
      setMask.faultFlag = events.faultEvt;                     // RULE_04
   end

   // Set is applied after clear so a same-cycle event is never lost
   always_comb begin
      next_flags = (flags & ~clearMask) | setMask;             // RULE_09
   end

   // Flags only change by hardware set or software clear
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         flags <= dcs_pkg::dcs_flags_t'(dcs_pkg::STATUS_RST[3:0]); // RULE_06
      end else if (clkEn) begin
         flags <= next_flags;                                  // RULE_05
      end
   end

endmodule

`default_nettype wire

// ---- src/dcs_pkg.sv ----
// Operation
// RULE_01: Any fault, halfway or done event sets the channel's any-event flag.
// RULE_02: A finished channel transfer sets that channel's done flag.
// RULE_03: Half the programmed transfer moved sets the channel's halfway flag.
// RULE_04: A failed bus access of a channel sets its fault flag.
// RULE_05: Flags are read-only, set by hardware, cleared by writing ones.
// RULE_06: Flags read one after an event, zero otherwise; all reset to zero.
// RULE_07: Four bits per channel: any-event, done, halfway, fault, from bit 0.
// RULE_08: Write-only clear register at 0x04: ones clear flags, zeros ignored.
// RULE_09: A set and a clear of one flag in one cycle leave it set.
`default_nettype none

package dcs_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Geometry of the status word
   localparam int NUM_CH       = 8;
   localparam int FLAGS_PER_CH = 4;
   localparam int DATA_W       = 32;
   localparam int ADDR_W       = 4;
   localparam int LANES        = 4;
   localparam int LANE_W       = 8;

   // Flag positions inside one channel nibble
   localparam int FLAG_ANY_POS   = 0;
   localparam int FLAG_DONE_POS  = 1;
   localparam int FLAG_HALF_POS  = 2;
   localparam int FLAG_FAULT_POS = 3;

   ////////////////////////////////////////////////////////////////////////////
   // Register byte addresses
   localparam logic [ADDR_W-1:0] STATUS_ADDR = 4'h0;
   localparam logic [ADDR_W-1:0] CLEAR_ADDR  = 4'h4;
   localparam logic [ADDR_W-1:0] ENABLE_ADDR = 4'h8;

   // Values after reset
   localparam logic [DATA_W-1:0] STATUS_RST = 32'h0000_0000;
   localparam logic [DATA_W-1:0] ENABLE_RST = 32'h0000_0000;
   localparam logic [DATA_W-1:0] ZERO_WORD  = 32'h0000_0000;

   // Avalon response codes
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   ////////////////////////////////////////////////////////////////////////////
   // Carriers
   // Event pulses from one channel transfer engine
   typedef struct packed {
      logic faultEvt;   // Bus access failed
      logic halfEvt;    // Half of the transfer moved
      logic doneEvt;    // Transfer finished
   } dcs_evt_t;

   // One channel nibble, listed from bit 3 down to bit 0
   typedef struct packed {
      logic faultFlag;
      logic halfFlag;
      logic doneFlag;
      logic anyFlag;
   } dcs_flags_t;

   // Bus handshake states
   typedef enum logic {
      BUS_IDLE,
      BUS_ACK
   } dcs_bus_state_t;

endpackage

`default_nettype wire

// ---- src/dcs_status_flags.sv ----
`default_nettype none

module dcs_status_flags (
   input  wire logic                      ref_clk,         // 40 MHz clock
   input  wire logic                      rst_n,           // Async reset
   input  wire logic                      clkEn,           // Clock enable
   input  wire dcs_pkg::dcs_evt_t [7:0]   chanEvents,      // Engine pulses
   input  wire logic [3:0]                avs_address,     // Byte address
   input  wire logic                      avs_read,        // Read request
   input  wire logic                      avs_write,       // Write request
   input  wire logic [31:0]               avs_writedata,   // Write data
   input  wire logic [3:0]                avs_byteenable,  // Byte lanes
   output logic                           avs_waitrequest, // Stall
   output logic [31:0]                    avs_readdata,    // Read data
   output logic [1:0]                     avs_response,    // Read status
   output logic                           irq              // Level irq
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   dcs_pkg::dcs_flags_t            cellFlags [dcs_pkg::NUM_CH];
   dcs_pkg::dcs_flags_t            cellClear [dcs_pkg::NUM_CH];
   logic [dcs_pkg::DATA_W-1:0]     statusWord;
   logic [dcs_pkg::DATA_W-1:0]     laneMask;
   logic [dcs_pkg::DATA_W-1:0]     clearWord;
   logic [dcs_pkg::DATA_W-1:0]     enableReg;
   logic [dcs_pkg::DATA_W-1:0]     next_enableReg;
   dcs_pkg::dcs_bus_state_t        busState;
   dcs_pkg::dcs_bus_state_t        next_busState;
   logic                           next_waitRq;
   logic [dcs_pkg::DATA_W-1:0]     next_readData;
   logic [1:0]                     next_response;
   logic                           next_irq;
   logic                           busReq;
   logic                           writeCommit;

   ////////////////////////////////////////////////////////////////////////////
   // Byte lanes widened to a bit mask
   genvar lane;
   generate
      for (lane = 0; lane < dcs_pkg::LANES; lane++) begin : g_lane
         assign laneMask[lane*dcs_pkg::LANE_W +: dcs_pkg::LANE_W] =
            {dcs_pkg::LANE_W{avs_byteenable[lane]}};
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Bus request qualifiers
   // A write takes effect only at the edge where waitrequest is seen low
   assign busReq      = avs_read | avs_write;
   assign writeCommit = avs_write & ~avs_waitrequest;

   // Clear strobe, one cycle, only on the flag-clear address
   always_comb begin
      clearWord = dcs_pkg::ZERO_WORD;
      if (writeCommit && (avs_address == dcs_pkg::CLEAR_ADDR)) begin
         clearWord = avs_writedata & laneMask;                 // RULE_08
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Per-channel flag cells, four bits each from bit 0 upward
   genvar ch;
   generate
      for (ch = 0; ch < dcs_pkg::NUM_CH; ch++) begin : g_chan
         assign cellClear[ch] = dcs_pkg::dcs_flags_t'(
            clearWord[ch*dcs_pkg::FLAGS_PER_CH +: dcs_pkg::FLAGS_PER_CH]);
         assign statusWord[ch*dcs_pkg::FLAGS_PER_CH +:
                           dcs_pkg::FLAGS_PER_CH] = cellFlags[ch]; // RULE_07

         dcs_channel_flags u_flags (
            .ref_clk   (ref_clk),
            .rst_n     (rst_n),
            .clkEn     (clkEn),
            .events    (chanEvents[ch]),
            .clearMask (cellClear[ch]),
            .flags     (cellFlags[ch])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt enable register, byte-lane writable
   always_comb begin
      next_enableReg = enableReg;
      if (writeCommit && (avs_address == dcs_pkg::ENABLE_ADDR)) begin
         next_enableReg = (enableReg & ~laneMask)
                        | (avs_writedata & laneMask);
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         enableReg <= dcs_pkg::ENABLE_RST;
      end else if (clkEn) begin
         enableReg <= next_enableReg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt level; registered, so it trails the flags by one cycle
   always_comb begin
      next_irq = |(statusWord & enableReg);
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else if (clkEn) begin
         irq <= next_irq;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus handshake: one stall cycle, then waitrequest low for one cycle.
   // Read data are a snapshot taken as the answer is set up; an event in
   // the answer cycle shows on the next read rather than being lost.
   always_comb begin
      next_busState = busState;
      next_waitRq   = 1'b1;
      next_readData = avs_readdata;
      next_response = avs_response;
      case (busState)
         dcs_pkg::BUS_IDLE: begin
            if (busReq) begin
               next_busState = dcs_pkg::BUS_ACK;
               next_waitRq   = 1'b0;
               next_readData = dcs_pkg::ZERO_WORD;
               next_response = dcs_pkg::RESP_OKAY;
               if (avs_address == dcs_pkg::STATUS_ADDR) begin
                  next_readData = statusWord;                  // RULE_05
               end else if (avs_address == dcs_pkg::ENABLE_ADDR) begin
                  next_readData = enableReg;
               end else if (avs_address == dcs_pkg::CLEAR_ADDR) begin
                  // Write-only register reads as zero
                  next_readData = dcs_pkg::ZERO_WORD;          // RULE_08
               end else begin
                  next_response = dcs_pkg::RESP_DECERR;
               end
            end
         end
         dcs_pkg::BUS_ACK: begin
            next_busState = dcs_pkg::BUS_IDLE;
         end
         default: begin
            next_busState = dcs_pkg::BUS_IDLE;
         end
      endcase
   end

   // Bus registers; waitrequest is high in reset so nothing is taken early
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         busState        <= dcs_pkg::BUS_IDLE;
         avs_waitrequest <= 1'b1;
         avs_readdata    <= dcs_pkg::ZERO_WORD;
         avs_response    <= dcs_pkg::RESP_OKAY;
      end else if (clkEn) begin
         busState        <= next_busState;
         avs_waitrequest <= next_waitRq;
         avs_readdata    <= next_readData;
         avs_response    <= next_response;
      end
   end

endmodule

`default_nettype wire

// ---- verif/dcs_status_flags_asserts.sv ----
`default_nettype none

module dcs_status_flags_asserts (
   input wire logic                    ref_clk,         // Clock
   input wire logic                    rst_n,           // Async reset
   input wire logic                    clkEn,           // Clock enable
   input wire dcs_pkg::dcs_evt_t [7:0] chanEvents,      // Engine pulses
   input wire logic [3:0]              avs_address,     // Byte address
   input wire logic                    avs_read,        // Read request
   input wire logic                    avs_write,       // Write request
   input wire logic                    avs_waitrequest, // Stall
   input wire logic [31:0]             avs_readdata,    // Read data
   input wire logic [1:0]              avs_response,    // Read status
   input wire logic                    irq              // Level irq
);
   logic wrDone;
   logic evAny;
   logic unmapped;

   // Helpers; only a landed write or an engine pulse may move the irq
   assign wrDone   = avs_write && !avs_waitrequest;
   assign evAny    = |chanEvents;
   assign unmapped = !(avs_address inside {dcs_pkg::STATUS_ADDR,
                       dcs_pkg::CLEAR_ADDR, dcs_pkg::ENABLE_ADDR});

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   ////////////////////////////////////////////////////////////////////////
   // Bus handshake
   chk_wait_answer: assert property (
      ($rose(avs_read) || $rose(avs_write)) && clkEn |=> !avs_waitrequest)
      else $error("request not answered in one cycle");
   chk_wait_single: assert property (
      !avs_waitrequest && clkEn |=> avs_waitrequest)
      else $error("answer held longer than one cycle");
   chk_idle_stall: assert property (
      !avs_read && !avs_write |=> avs_waitrequest)
      else $error("answer without request");
   chk_unmapped_read: assert property (
      avs_read && !avs_waitrequest && unmapped |->
      avs_response == dcs_pkg::RESP_DECERR && avs_readdata == 32'h0000_0000)
      else $error("unmapped read not refused");
   chk_clear_reads_zero: assert property (
      avs_read && !avs_waitrequest && avs_address == dcs_pkg::CLEAR_ADDR |->
      avs_response == dcs_pkg::RESP_OKAY && avs_readdata == 32'h0000_0000)
      else $error("clear register not write-only");
   chk_reset_quiet: assert property (
      $rose(rst_n) |->
      avs_waitrequest && !irq && avs_readdata == 32'h0000_0000)
      else $error("outputs not quiet after reset");
   chk_irq_fall_cause: assert property (
      $fell(irq) |-> $past(wrDone, 2))
      else $error("irq dropped without software write");
   chk_irq_rise_cause: assert property (
      $rose(irq) |-> $past(evAny, 2) || $past(wrDone, 2))
      else $error("irq rose without event or enable write");

   // Main scenarios
   cov_unmapped: cover property (avs_read && !avs_waitrequest && unmapped);
   cov_irq_rise: cover property ($rose(irq));
   cov_clear: cover property (wrDone && avs_address == dcs_pkg::CLEAR_ADDR);
endmodule

bind dcs_status_flags dcs_status_flags_asserts i_dcs_status_flags_asserts (
   .ref_clk(ref_clk), .rst_n(rst_n), .clkEn(clkEn), .chanEvents(chanEvents),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
   .avs_response(avs_response), .irq(irq));

`default_nettype wire

// ---- verif/test_dcs_status_flags.sv ----
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; \
   $display("BAD t=%0t got %h exp %h", $time, (a), (b)); end end

module test_dcs_status_flags;
   timeunit 1ns;
   timeprecision 100ps;
   logic                    ref_clk;
   logic                    rst_n;
   logic                    clkEn;
   dcs_pkg::dcs_evt_t [7:0] chanEvents;
   logic [3:0]              avs_address;
   logic                    avs_read;
   logic                    avs_write;
   logic [31:0]             avs_writedata;
   logic [3:0]              avs_byteenable;
   logic                    avs_waitrequest;
   logic [31:0]             avs_readdata;
   logic [1:0]              avs_response;
   logic                    irq;
   logic [31:0]             rdat;
   logic [1:0]              rsp;
   logic [31:0]             exp;
   int                      errors;
   int                      compares;

   dcs_status_flags i_dcs_status_flags (
      .ref_clk(ref_clk), .rst_n(rst_n), .clkEn(clkEn),
      .chanEvents(chanEvents), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
      .avs_response(avs_response), .irq(irq));

   ////////////////////////////////////////////////////////////////////////
   // 40 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   task automatic summarize();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // One Avalon access; request held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [3:0] a,
                      input logic [31:0] d, input logic [3:0] be);
      int n;
      n = 0;
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      if (wr) avs_write <= 1'b1;
      else avs_read <= 1'b1;
      @(posedge ref_clk);
      while (avs_waitrequest !== 1'b0) begin
         n++;
         if (n > 50) begin
            errors++;
            summarize();
         end
         @(posedge ref_clk);
      end
      rdat = avs_readdata;
      rsp = avs_response;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic rdChk(input logic [3:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0000_0000, 4'hf);
      `CHK(rdat, e)
   endtask

   // One-cycle pulse of event kind k (0 done, 1 halfway, 2 fault)
   task automatic pulse(input int c, input int k);
      dcs_pkg::dcs_evt_t [7:0] ev;
      ev = '0;
      ev[c] = dcs_pkg::dcs_evt_t'(3'b001 << k);
      @(posedge ref_clk);
      chanEvents <= ev;
      @(posedge ref_clk);
      chanEvents <= '0;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Main sequence; clkEn stays high except in the freeze test
   initial begin
      errors = 0;
      compares = 0;
      rst_n = 1'b0;
      clkEn = 1'b1;
      chanEvents = '0;
      avs_address = 4'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0000_0000;
      avs_byteenable = 4'h0;
      repeat (16) @(posedge ref_clk);
      rst_n <= 1'b1;
      rdChk(dcs_pkg::STATUS_ADDR, dcs_pkg::STATUS_RST);
      rdChk(dcs_pkg::ENABLE_ADDR, dcs_pkg::ENABLE_RST);
      $display("test reset done");
      for (int c = 0; c < 8; c++) begin
         for (int k = 0; k < 3; k++) begin
            pulse(c, k);
            exp = (32'h0000_0001 << (4 * c))
                | (32'h0000_0001 << (4 * c + 1 + k));
            rdChk(dcs_pkg::STATUS_ADDR, exp);
            bus(1'b1, dcs_pkg::CLEAR_ADDR, 32'h0000_0000, 4'hf);
            bus(1'b1, dcs_pkg::STATUS_ADDR, 32'hffff_ffff, 4'hf);
            rdChk(dcs_pkg::STATUS_ADDR, exp);
            bus(1'b1, dcs_pkg::CLEAR_ADDR, exp, 4'hf);
            rdChk(dcs_pkg::STATUS_ADDR, 32'h0000_0000);
         end
      end
      $display("test set and clear done");
      // Any-event flag cleared alone, then only byte lane 1 cleared
      pulse(3, 0);
      bus(1'b1, dcs_pkg::CLEAR_ADDR, 32'h0000_1000, 4'hf);
      rdChk(dcs_pkg::STATUS_ADDR, 32'h0000_2000);
      pulse(4, 0);
      bus(1'b1, dcs_pkg::CLEAR_ADDR, 32'hffff_ffff, 4'h2);
      rdChk(dcs_pkg::STATUS_ADDR, 32'h0003_0000);
      bus(1'b1, dcs_pkg::CLEAR_ADDR, 32'hffff_ffff, 4'hf);
      $display("test partial clear done");
      // Event held across a clear of its own flag: the commit edge sees
      // set and clear together, and nothing sets the flag after it
      @(posedge ref_clk);
      chanEvents[2].doneEvt <= 1'b1;
      bus(1'b1, dcs_pkg::CLEAR_ADDR, 32'h0000_0200, 4'hf);
      chanEvents <= '0;
      rdChk(dcs_pkg::STATUS_ADDR, 32'h0000_0300);
      $display("test set wins done");
      // Enabled flag raises irq, a masked one does not
      bus(1'b1, dcs_pkg::ENABLE_ADDR, 32'h0000_0200, 4'hf);
      rdChk(dcs_pkg::ENABLE_ADDR, 32'h0000_0200);
      repeat (2) @(posedge ref_clk);
      `CHK(irq, 1'b1)
      bus(1'b1, dcs_pkg::CLEAR_ADDR, 32'h0000_0300, 4'hf);
      pulse(5, 1);
      repeat (3) @(posedge ref_clk);
      `CHK(irq, 1'b0)
      $display("test irq done");
      // Unmapped, misaligned and write-only places
      bus(1'b0, 4'hc, 32'h0000_0000, 4'hf);
      `CHK(rsp, dcs_pkg::RESP_DECERR)
      bus(1'b0, 4'h2, 32'h0000_0000, 4'hf);
      `CHK(rsp, dcs_pkg::RESP_DECERR)
      rdChk(dcs_pkg::CLEAR_ADDR, 32'h0000_0000);
      `CHK(rsp, dcs_pkg::RESP_OKAY)
      $display("test address map done");
      // Nothing is taken while the clock enable is low
      clkEn <= 1'b0;
      pulse(0, 0);
      clkEn <= 1'b1;
      rdChk(dcs_pkg::STATUS_ADDR, 32'h0050_0000);
      $display("test freeze done");
      // Reset in mid-run clears the flags and the enable register
      @(posedge ref_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      rdChk(dcs_pkg::STATUS_ADDR, dcs_pkg::STATUS_RST);
      rdChk(dcs_pkg::ENABLE_ADDR, dcs_pkg::ENABLE_RST);
      $display("test mid reset done");
      summarize();
   end
endmodule

`default_nettype wire
